//--- irqpp_pkg.sv
// constants, register map and helper functions for the interrupt priority and pending logic
package irqpp_pkg;
   // =====================================================================
   // sizes
   localparam int NUM_IRQ = 33; // interrupt lines handled
   localparam int IRQ_W = 6; // width of an interrupt number
   localparam int PRIO_W = 4; // implemented priority bits per field
   localparam int LANE_W = 8; // width of one priority byte lane
   localparam int PRIO_LSB = 4; // field sits in bits 7:4 of its lane
   localparam int LANES = 4; // priority fields per register
   localparam int SGI_W = 9; // trigger number field width
   localparam int ADDR_W = 12; // decoded byte address width
   localparam int SYNC_STAGES = 2; // flip-flops in the reset release shift register

   // =====================================================================
   // register map, byte addresses
   localparam logic [11:0] OFS_PRIO_FIRST = 12'h000; // first priority register
   localparam logic [11:0] OFS_PRIO_LAST = 12'h020; // ninth priority register
   localparam logic [11:0] OFS_ENA_SET = 12'h100; // enable set, two words
   localparam logic [11:0] OFS_ENA_CLR = 12'h180; // enable clear, two words
   localparam logic [11:0] OFS_PEND_SET = 12'h200; // pending set, two words
   localparam logic [11:0] OFS_PEND_CLR = 12'h280; // pending clear, two words
   localparam logic [11:0] OFS_ACTIVE = 12'h300; // active flags, two words
   localparam logic [11:0] OFS_SOFT_TRIG = 12'hE00; // soft_trigger_reg, write only
   localparam logic [11:0] OFS_SYS_CTRL = 12'hE10; // system_ctrl_reg
   localparam int UNPRIV_BIT = 0; // unpriv_trigger_allow position

   // =====================================================================
   // reset values and bus codes
   localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
   localparam logic [NUM_IRQ-1:0] VEC_RST = '0;
   localparam logic ALLOW_RST = 1'b0;
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;

   // =====================================================================
   // one 32-bit word of a bitmap, word 0 or 1
   function automatic logic [31:0] vec_word(input logic [NUM_IRQ-1:0] v, input logic hi);
      logic [63:0] p;
      p = 64'(v);
      return hi ? p[63:32] : p[31:0];
   endfunction : vec_word

   // spread a written word onto the bitmap, word 0 or 1
   function automatic logic [NUM_IRQ-1:0] wr_vec(input logic [31:0] d, input logic hi);
      logic [63:0] p;
      p = hi ? {d, 32'h0000_0000} : {32'h0000_0000, d};
      return p[NUM_IRQ-1:0];
   endfunction : wr_vec
endpackage : irqpp_pkg

//--- irqpp_ahb_slave.sv
// ahb-lite slave front end: address phase capture, byte lanes, read wait state
`timescale 1ns/100ps
module irqpp_ahb_slave (
   input wire logic mclk,
   input wire logic rstN,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic hready,
   input wire logic [31:0] rdData,
   output logic wrStrobe,
   output logic [irqpp_pkg::ADDR_W-1:0] regAddr,
   output logic [3:0] byteEn,
   output logic accPriv,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import irqpp_pkg::*;

   logic takeReq; // valid transfer seen in address phase
   logic [3:0] laneMask; // byte lanes touched by this transfer
   logic dphWr; // write data phase in progress
   logic dphRd; // read data phase in progress
   logic rdDone; // read data already latched

   // =====================================================================
   // address phase decode
   assign takeReq = hsel & htrans[1] & hready;
   // byte lanes allow one priority field to change alone
   assign laneMask = (hsize == HSIZE_BYTE) ? (4'h1 << haddr[1:0]) :
                     (hsize == HSIZE_HALF) ? (haddr[1] ? 4'hC : 4'h3) : 4'hF;

   // capture the address phase; hold it while a read waits
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         dphWr <= 1'b0;
         dphRd <= 1'b0;
         regAddr <= '0;
         byteEn <= 4'h0;
         accPriv <= 1'b0;
      end else if (hready) begin
         dphWr <= takeReq & hwrite;
         dphRd <= takeReq & ~hwrite;
         if (takeReq) begin
            regAddr <= haddr[ADDR_W-1:0];
            byteEn <= laneMask;
            accPriv <= hprot[1];
         end
      end
   end

   // one wait state on reads so hrdata comes from a flip-flop
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         rdDone <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         rdDone <= dphRd & ~rdDone;
         if (dphRd & ~rdDone) begin
            hrdata <= rdData;
         end
      end
   end

   // =====================================================================
   // handshake; writes finish with no wait, the response is always okay
   assign wrStrobe = dphWr;
   assign hreadyout = ~(dphRd & ~rdDone);
   assign hresp = 1'b0;
endmodule : irqpp_ahb_slave

//--- irqpp_prio_select.sv
// picks the requestable interrupt with the smallest priority value
`timescale 1ns/100ps
module irqpp_prio_select (
   input wire logic [irqpp_pkg::NUM_IRQ-1:0] cand,
   input wire logic [irqpp_pkg::NUM_IRQ*irqpp_pkg::PRIO_W-1:0] prioFlat,
   output logic found,
   output logic [irqpp_pkg::IRQ_W-1:0] winNum,
   output logic [irqpp_pkg::PRIO_W-1:0] winPrio
);
   import irqpp_pkg::*;

   // =====================================================================
   // scan from the top down so that on equal priority the lower number wins
   always_comb begin
      found = 1'b0;
      winNum = '0;
      winPrio = '1;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         // smaller value is the stronger claim
         if (cand[i] && (!found || prioFlat[i*PRIO_W +: PRIO_W] <= winPrio)) begin
            found = 1'b1;
            winNum = IRQ_W'(i);
            winPrio = prioFlat[i*PRIO_W +: PRIO_W];
         end
      end
   end
endmodule : irqpp_prio_select

//--- irqpp_top.sv
// interrupt priority, software trigger and pending state tracking with ahb-lite registers
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module irqpp_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [irqpp_pkg::NUM_IRQ-1:0] irqLine,
   input wire logic coreEnter,
   input wire logic [irqpp_pkg::IRQ_W-1:0] coreEnterNum,
   input wire logic coreReturn,
   input wire logic [irqpp_pkg::IRQ_W-1:0] coreReturnNum,
   output logic reqValid,
   output logic [irqpp_pkg::IRQ_W-1:0] reqNum,
   output logic [irqpp_pkg::PRIO_W-1:0] reqPrio
);
   import irqpp_pkg::*;

   // =====================================================================
   // reset release
   logic [SYNC_STAGES-1:0] rstPipe; // release shift register
   logic rstN; // synchronised active-low reset for all logic

   // assert at once, release two edges later so no flop leaves reset mid-cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstPipe <= '0;
      end else begin
         rstPipe <= {rstPipe[SYNC_STAGES-2:0], 1'b1};
      end
   end
   assign rstN = rstPipe[SYNC_STAGES-1];

   // =====================================================================
   // request line synchronisers
   logic [NUM_IRQ-1:0] lineMeta; // first stage, read only by lineSync
   logic [NUM_IRQ-1:0] lineSync; // safe copy of the request lines
   logic [NUM_IRQ-1:0] linePrev; // lineSync one cycle ago, for edges

   // peripherals may run on other clocks, so every line is resynchronised
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         lineMeta <= VEC_RST;
         lineSync <= VEC_RST;
         linePrev <= VEC_RST;
      end else begin
         lineMeta <= irqLine;
         lineSync <= lineMeta;
         linePrev <= lineSync;
      end
   end

   // =====================================================================
   // bus slave
   logic wrStrobe; // write data phase, hwdata valid
   logic [ADDR_W-1:0] regAddr; // captured byte address
   logic [3:0] byteEn; // captured byte lanes
   logic accPriv; // captured privilege of the access
   logic [31:0] rdData; // read mux result

   irqpp_ahb_slave uSlave (
      .mclk(mclk),
      .rstN(rstN),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hprot(hprot),
      .hready(hready),
      .rdData(rdData),
      .wrStrobe(wrStrobe),
      .regAddr(regAddr),
      .byteEn(byteEn),
      .accPriv(accPriv),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp)
   );

   // =====================================================================
   // address decode
   logic isPrio; // one of the nine priority registers
   logic [3:0] prioIdx; // which priority register
   logic wordHi; // upper word of a two-word bitmap
   logic isEnaSet; // enable set pair
   logic isEnaClr; // enable clear pair
   logic isPendSet; // pending set pair
   logic isPendClr; // pending clear pair
   logic isActive; // active flag pair
   logic isTrig; // soft_trigger_reg
   logic isSys; // system_ctrl_reg
   logic allow; // unpriv_trigger_allow
   logic wrOk; // write accepted after privilege check
   logic [31:0] wData; // write data with unselected bytes dropped

   assign isPrio = regAddr[11:2] <= OFS_PRIO_LAST[11:2];
   assign prioIdx = regAddr[5:2];
   assign wordHi = regAddr[2];
   assign isEnaSet = regAddr[11:3] == OFS_ENA_SET[11:3];
   assign isEnaClr = regAddr[11:3] == OFS_ENA_CLR[11:3];
   assign isPendSet = regAddr[11:3] == OFS_PEND_SET[11:3];
   assign isPendClr = regAddr[11:3] == OFS_PEND_CLR[11:3];
   assign isActive = regAddr[11:3] == OFS_ACTIVE[11:3];
   assign isTrig = regAddr[11:2] == OFS_SOFT_TRIG[11:2];
   assign isSys = regAddr[11:2] == OFS_SYS_CTRL[11:2];
   // unprivileged writes land only on the trigger, and only when allowed
   assign wrOk = wrStrobe & (accPriv | (isTrig & allow));
   assign wData = hwdata & {{8{byteEn[3]}}, {8{byteEn[2]}}, {8{byteEn[1]}}, {8{byteEn[0]}}};

   // =====================================================================
   // system control: privileged writes only
   logic [31:0] sysWord; // read view of system_ctrl_reg

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         allow <= ALLOW_RST;
      end else if (wrOk && isSys && accPriv) begin
         allow <= wData[UNPRIV_BIT];
      end
   end
   assign sysWord = 32'(allow) << UNPRIV_BIT;

   // =====================================================================
   // priority fields
   logic [PRIO_W-1:0] prio [NUM_IRQ]; // stored upper nibble of each field
   logic [NUM_IRQ-1:0] prioWr; // field write strobe per interrupt
   logic [NUM_IRQ*PRIO_W-1:0] prioFlat; // fields packed for the selector
   logic [31:0] prioWord; // read view of the addressed register

   for (genvar g = 0; g < NUM_IRQ; g++) begin : gPrio
      // register g/4, lane g%4, each lane written only if its byte is selected
      assign prioWr[g] = wrOk && isPrio && prioIdx == 4'(g / LANES) && byteEn[g % LANES];
      assign prioFlat[g*PRIO_W +: PRIO_W] = prio[g];
   end

   // only bits 7:4 of a lane are kept; bits 3:0 are thrown away
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < NUM_IRQ; i++) begin
            prio[i] <= PRIO_RST;
         end
      end else begin
         for (int i = 0; i < NUM_IRQ; i++) begin
            if (prioWr[i]) begin
               prio[i] <= wData[(i % LANES)*LANE_W + PRIO_LSB +: PRIO_W];
            end
         end
      end
   end

   // low nibble of every lane reads zero; lanes past the last irq read zero
   always_comb begin
      prioWord = 32'h0000_0000;
      for (int j = 0; j < LANES; j++) begin
         if (int'(prioIdx) * LANES + j < NUM_IRQ) begin
            prioWord[j*LANE_W + PRIO_LSB +: PRIO_W] = prio[int'(prioIdx) * LANES + j];
         end
      end
   end

   // =====================================================================
   // enable, pending and active state
   logic [NUM_IRQ-1:0] enable; // irq_enable_set state
   logic [NUM_IRQ-1:0] pending; // pending flags
   logic [NUM_IRQ-1:0] active; // active flags
   logic [NUM_IRQ-1:0] enterVec; // core enters this handler now
   logic [NUM_IRQ-1:0] returnVec; // core returns from this handler now
   logic [NUM_IRQ-1:0] edgeVec; // rising edge on the line
   logic [NUM_IRQ-1:0] lvlVec; // line high where the level may pend
   logic [NUM_IRQ-1:0] swSetVec; // set-pending write
   logic [NUM_IRQ-1:0] swClrVec; // clear-pending write
   logic [NUM_IRQ-1:0] trigVec; // software_interrupt by number
   logic [NUM_IRQ-1:0] setVec; // all reasons to become pending
   logic [NUM_IRQ-1:0] clrVec; // all reasons to stop pending
   logic [NUM_IRQ-1:0] next_pending;
   logic [NUM_IRQ-1:0] next_active;
   logic [NUM_IRQ-1:0] next_enable;
   logic [SGI_W-1:0] sgiNum; // number written to the trigger

   assign enterVec = coreEnter ? ({{(NUM_IRQ-1){1'b0}}, 1'b1} << coreEnterNum) : VEC_RST;
   assign returnVec = coreReturn ? ({{(NUM_IRQ-1){1'b0}}, 1'b1} << coreReturnNum) : VEC_RST;
   assign edgeVec = lineSync & ~linePrev;
   // a high line pends while not active; on return it is sampled again
   assign lvlVec = lineSync & ((~active & ~enterVec) | returnVec);
   assign swSetVec = (wrOk && isPendSet) ? wr_vec(wData, wordHi) : VEC_RST;
   assign swClrVec = (wrOk && isPendClr) ? wr_vec(wData, wordHi) : VEC_RST;
   assign sgiNum = wData[SGI_W-1:0];
   // numbers beyond the last line match nothing and are ignored
   for (genvar g = 0; g < NUM_IRQ; g++) begin : gTrig
      assign trigVec[g] = wrOk && isTrig && sgiNum == SGI_W'(g);
   end
   // enable plays no part here: disabled lines still pend
   assign setVec = lvlVec | edgeVec | swSetVec | trigVec;
   // a clear-pending write loses to a line that is still high
   assign clrVec = enterVec | (swClrVec & ~lineSync);
   // set beats clear, so an edge during handler entry is kept
   assign next_pending = setVec | (pending & ~clrVec);
   // active is left alone by new pends; only a return clears it
   assign next_active = enterVec | (active & ~returnVec);
   assign next_enable = (enable | ((wrOk && isEnaSet) ? wr_vec(wData, wordHi) : VEC_RST))
                        & ~((wrOk && isEnaClr) ? wr_vec(wData, wordHi) : VEC_RST);

   // state update
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         pending <= VEC_RST;
         active <= VEC_RST;
         enable <= VEC_RST;
      end else begin
         pending <= next_pending;
         active <= next_active;
         enable <= next_enable;
      end
   end

   // =====================================================================
   // request to the core
   logic [NUM_IRQ-1:0] cand; // pending, enabled and not yet active
   logic found; // a candidate exists
   logic [IRQ_W-1:0] winNum; // strongest candidate
   logic [PRIO_W-1:0] winPrio; // its priority

   // a disabled line can sit pending forever without being offered
   assign cand = pending & enable & ~active;

   irqpp_prio_select uSelect (
      .cand(cand),
      .prioFlat(prioFlat),
      .found(found),
      .winNum(winNum),
      .winPrio(winPrio)
   );

   // registered so the core sees a stable number and priority
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         reqValid <= 1'b0;
         reqNum <= '0;
         reqPrio <= PRIO_RST;
      end else begin
         reqValid <= found;
         reqNum <= winNum;
         reqPrio <= winPrio;
      end
   end

   // =====================================================================
   // read mux; the trigger is write only and unmapped words read zero
   assign rdData = isPrio ? prioWord :
                   (isEnaSet || isEnaClr) ? vec_word(enable, wordHi) :
                   (isPendSet || isPendClr) ? vec_word(pending, wordHi) :
                   isActive ? vec_word(active, wordHi) :
                   isSys ? sysWord : 32'h0000_0000;

   // =====================================================================
   // checks
   default clocking cbChk @(posedge mclk); endclocking
   default disable iff (!rstN);

   for (genvar g = 0; g < NUM_IRQ; g++) begin : gChk
      property p_enter;
         coreEnter && coreEnterNum == IRQ_W'(g) && !edgeVec[g] && !wrStrobe
         |=> active[g] && !pending[g];
      endproperty
      a_enter: assert property (p_enter)
         else $error("handler entry did not move pending to active");

      property p_return_level;
         active[g] && coreReturn && coreReturnNum == IRQ_W'(g) && lineSync[g]
         |=> pending[g] && !active[g];
      endproperty
      a_return_level: assert property (p_return_level)
         else $error("return with line high did not re-pend");

      property p_return_quiet;
         coreReturn && coreReturnNum == IRQ_W'(g) && !lineSync[g] && !pending[g] && !wrStrobe
         |=> !pending[g] && !active[g];
      endproperty
      a_return_quiet: assert property (p_return_quiet)
         else $error("quiet return did not go inactive");

      property p_edge;
         lineSync[g] && !linePrev[g] |=> pending[g];
      endproperty
      a_edge: assert property (p_edge)
         else $error("rising edge did not set pending");

      property p_level;
         lineSync[g] && !active[g] && !(coreEnter && coreEnterNum == IRQ_W'(g))
         |=> pending[g];
      endproperty
      a_level: assert property (p_level)
         else $error("high line on inactive irq did not pend");

      property p_clear_hold;
         swClrVec[g] && lineSync[g] && pending[g] && !enterVec[g] |=> pending[g];
      endproperty
      a_clear_hold: assert property (p_clear_hold)
         else $error("clear-pending dropped a still asserted line");

      property p_disabled;
         !enable[g] [*2] |-> !(reqValid && reqNum == IRQ_W'(g));
      endproperty
      a_disabled: assert property (p_disabled)
         else $error("disabled interrupt offered to the core");

      property p_both;
         active[g] && edgeVec[g] && !returnVec[g] |=> pending[g] && active[g];
      endproperty
      a_both: assert property (p_both)
         else $error("edge during handler lost pending or active");

      // trigger decode checked apart from trigVec
      property p_trig;
         wrOk && isTrig && wData[SGI_W-1:0] == SGI_W'(g) |=> pending[g];
      endproperty
      a_trig: assert property (p_trig)
         else $error("trigger write did not set pending");

      property p_set_pend;
         wrOk && isPendSet && wData[g % 32] && (wordHi == (g >= 32)) |=> pending[g];
      endproperty
      a_set_pend: assert property (p_set_pend)
         else $error("set-pending write did not set pending");
   end

   // an unprivileged write never moves the allow bit
   property p_allow_priv;
      wrStrobe && !accPriv |=> $stable(allow);
   endproperty
   a_allow_priv: assert property (p_allow_priv)
      else $error("unprivileged write changed the allow bit");
endmodule : irqpp_top

//--- irqpp_core_model.sv
// model of the peripheral request lines and the core handler handshake
`timescale 1ns/100ps
module irqpp_core_model (
   input wire logic mclk,
   output logic [irqpp_pkg::NUM_IRQ-1:0] irqLine,
   output logic coreEnter,
   output logic [irqpp_pkg::IRQ_W-1:0] coreEnterNum,
   output logic coreReturn,
   output logic [irqpp_pkg::IRQ_W-1:0] coreReturnNum
);
   import irqpp_pkg::*;
   // lines low from time zero, so reset release sees no edge
   initial begin
      irqLine = '0;
      coreEnter = 1'b0;
      coreReturn = 1'b0;
      coreEnterNum = '0;
      coreReturnNum = '0;
   end
   // a level request stays as set until the handler side drops it
   task automatic level(input int n, input logic v);
      @(posedge mclk);
      irqLine[n] <= v;
   endtask : level
   // one-cycle entry (e=1) or return pulse; number scrambled when idle
   task automatic core(input logic e, input int n);
      @(posedge mclk);
      coreEnter <= e;
      coreReturn <= !e;
      coreEnterNum <= IRQ_W'(n);
      coreReturnNum <= IRQ_W'(n);
      @(posedge mclk);
      coreEnter <= 1'b0;
      coreReturn <= 1'b0;
      coreEnterNum <= ~IRQ_W'(n);
      coreReturnNum <= ~IRQ_W'(n);
   endtask : core
endmodule : irqpp_core_model

//--- tb_irq_priority_pending_logic.sv
// self-checking testbench for the priority and pending logic
`timescale 1ns/100ps
module tb_irq_priority_pending_logic;
   import irqpp_pkg::*;
   // =====================================================================
   // signals and bench state
   logic mclk, resetn, hsel, hwrite, hreadyout, hresp, reqValid, coreEnter, coreReturn;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] hprot;
   logic [NUM_IRQ-1:0] irqLine;
   logic [IRQ_W-1:0] coreEnterNum, coreReturnNum, reqNum;
   logic [PRIO_W-1:0] reqPrio;
   logic [7:0] pr [0:35]; // expected priority bytes
   logic [7:0] v;
   logic [15:0] seed = 16'h8DF5;
   int num_errors = 0, total_checks = 0, cyc = 0, n, a, b, w;
   irqpp_top irqpp_top_i (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irqLine(irqLine),
      .coreEnter(coreEnter), .coreEnterNum(coreEnterNum), .coreReturn(coreReturn),
      .coreReturnNum(coreReturnNum), .reqValid(reqValid), .reqNum(reqNum), .reqPrio(reqPrio));
   irqpp_core_model irqpp_core_model_i (.mclk(mclk), .irqLine(irqLine), .coreEnter(coreEnter),
      .coreEnterNum(coreEnterNum), .coreReturn(coreReturn), .coreReturnNum(coreReturnNum));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // hang guard: whole run needs far fewer cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         finish_test();
      end
   end
   // =====================================================================
   // helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one aligned single transfer; waits on hready, read data lands in rv
   task automatic bus(input logic [11:0] ad, input logic wr, input logic [31:0] d,
      input logic [2:0] sz, input logic pv);
      hsel <= 1'b1;
      haddr <= {20'h00000, ad};
      hwrite <= wr;
      hsize <= sz;
      hprot <= {2'h0, pv, 1'h1};
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      bus(ad, 1'b1, d, 3'h2, 1'b1);
   endtask : wr
   task automatic rd(input logic [11:0] ad);
      bus(ad, 1'b0, 32'h0000_0000, 3'h2, 1'b1);
   endtask : rd
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask : done
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   // =====================================================================
   // main sequence
   initial begin
      {hsel, hwrite, htrans, hsize, hprot, haddr, hwdata} = '0;
      resetn = 1'b0;
      for (int i = 0; i < 36; i++) pr[i] = 8'h00;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (5) @(posedge mclk);
      rd(OFS_SYS_CTRL);
      chk("allow reset", rv, 32'h0);
      rd(12'h400);
      chk("unmapped", rv, 32'h0);
      chk("okay", hresp, 32'h0);
      // byte writes of random fields, word read back
      for (int i = 0; i < 14; i++) begin
         seed = lfsr(seed);
         n = (i == 0) ? 32 : seed % 33;
         v = (i == 1) ? 8'hFF : seed[15:8];
         pr[n] = v & 8'hF0;
         bus(12'(4 * (n / 4) + n % 4), 1'b1, {4{v}}, HSIZE_BYTE, 1'b1);
         rd(12'(4 * (n / 4)));
         w = 4 * (n / 4);
         chk("prio", rv, {pr[w + 3], pr[w + 2], pr[w + 1], pr[w]});
      end
      // half-word write touches lanes 2 and 3 only
      bus(12'h006, 1'b1, 32'hA5A5_A5A5, HSIZE_HALF, 1'b1);
      pr[6] = 8'hA0;
      pr[7] = 8'hA0;
      rd(12'h004);
      chk("prio half", rv, {pr[7], pr[6], pr[5], pr[4]});
      done("priority");
      // disabled interrupt pends but is never requested
      wr(OFS_SOFT_TRIG, 32'h0000_0003);
      repeat (3) @(posedge mclk);
      chk("req disabled", reqValid, 32'h0);
      rd(OFS_PEND_SET);
      chk("soft pend", rv[3], 32'h1);
      // privilege of trigger and allow bit
      bus(OFS_SYS_CTRL, 1'b1, 32'h1, 3'h2, 1'b0);
      rd(OFS_SYS_CTRL);
      chk("unpriv allow", rv, 32'h0);
      bus(OFS_SOFT_TRIG, 1'b1, 32'h9, 3'h2, 1'b0);
      rd(OFS_PEND_SET);
      chk("unpriv trig", rv[9], 32'h0);
      wr(OFS_SYS_CTRL, 32'h1);
      bus(OFS_SOFT_TRIG, 1'b1, 32'h9, 3'h2, 1'b0);
      rd(OFS_PEND_SET);
      chk("allowed trig", rv[9], 32'h1);
      done("privilege");
      // arbitration between two random triggered interrupts
      wr(OFS_ENA_SET, 32'hFFFF_FFFF);
      wr(OFS_ENA_SET + 12'h4, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(OFS_PEND_CLR, 32'hFFFF_FFFF);
         wr(OFS_PEND_CLR + 12'h4, 32'h1);
         seed = lfsr(seed);
         a = seed % 33;
         b = seed[15:8] % 33;
         wr(OFS_SOFT_TRIG, 32'(a));
         wr(OFS_SOFT_TRIG, 32'(b));
         repeat (3) @(posedge mclk);
         w = (pr[b] < pr[a] || (pr[b] == pr[a] && b < a)) ? b : a;
         chk("req valid", reqValid, 32'h1);
         chk("req num", reqNum, 32'(w));
         chk("req prio", reqPrio, 32'(pr[w][7:4]));
      end
      wr(OFS_PEND_CLR, 32'hFFFF_FFFF);
      wr(OFS_PEND_CLR + 12'h4, 32'h1);
      // a number past the last line pends nothing
      wr(OFS_SOFT_TRIG, 32'h0000_00EF);
      rd(OFS_PEND_SET);
      chk("trig range", rv, 32'h0);
      wr(OFS_ENA_CLR, 32'hFFFF_FFFF);
      rd(OFS_ENA_SET);
      chk("ena clr", rv, 32'h0);
      done("arbitration");
      // level request through entry and return
      irqpp_core_model_i.level(5, 1'b1);
      repeat (4) @(posedge mclk);
      rd(OFS_PEND_SET);
      chk("level pend", rv[5], 32'h1);
      wr(OFS_PEND_CLR, 32'h20);
      rd(OFS_PEND_SET);
      chk("clr high", rv[5], 32'h1);
      irqpp_core_model_i.core(1'b1, 5);
      rd(OFS_ACTIVE);
      chk("active", rv[5], 32'h1);
      rd(OFS_PEND_SET);
      chk("entry", rv[5], 32'h0);
      irqpp_core_model_i.core(1'b0, 5);
      rd(OFS_PEND_SET);
      chk("repend", rv[5], 32'h1);
      irqpp_core_model_i.level(5, 1'b0);
      repeat (4) @(posedge mclk);
      wr(OFS_PEND_CLR, 32'h20);
      rd(OFS_PEND_SET);
      chk("clr low", rv[5], 32'h0);
      done("level");
      // edge while the handler runs, then a quiet handler
      wr(OFS_PEND_SET, 32'h80);
      irqpp_core_model_i.core(1'b1, 7);
      irqpp_core_model_i.level(7, 1'b1);
      irqpp_core_model_i.level(7, 1'b0);
      repeat (4) @(posedge mclk);
      rd(OFS_PEND_SET);
      chk("edge pend", rv[7], 32'h1);
      rd(OFS_ACTIVE);
      chk("still active", rv[7], 32'h1);
      irqpp_core_model_i.core(1'b1, 7);
      irqpp_core_model_i.core(1'b0, 7);
      rd(OFS_PEND_SET);
      chk("quiet pend", rv[7], 32'h0);
      rd(OFS_ACTIVE);
      chk("quiet act", rv[7], 32'h0);
      done("edge");
      finish_test();
   end
endmodule : tb_irq_priority_pending_logic
